/* File: design/gac_option_ctrl.sv */
// option-control logic and its transmit fifo
// Function
// - reception on: line preparatory pattern starts remote loopback.
// - reception off: line loopback requests are ignored.
// - reception off still allows sending our own loopback request.
// - clear channel carries user data only, at the selected rate.
// - octet mode embeds octet timing, a 128 kbps terminal stream.
// - octet mode ignores the rate setting; terminal runs at 128 kbps.
// - violations are transmitted only when insertion is enabled.
// - panel switches act only while panel enable is on.
// - terminal test requests act only while terminal acknowledge is on.
// - line transmit and receive run at once at 64 kbps.
// - local loopback returns terminal data to the terminal.
//
// The AXI4-Lite register port and the address map were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// flip-flop fifo, valid/ready both sides
module gac_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 in_valid,
  output logic                      in_ready,
  input  wire logic [W-1:0]         in_data,
  output logic                      out_valid,
  input  wire logic                 out_ready,
  output logic      [W-1:0]         out_data,
  output logic      [$clog2(D):0]   fill
);
  logic [W-1:0]           mem_r [D];
  logic [$clog2(D)-1:0]   wp_r;
  logic [$clog2(D)-1:0]   rp_r;
  logic [$clog2(D):0]     cnt_r;
  logic                   push;
  logic                   pop;

  assign in_ready  = (cnt_r != D[$clog2(D):0]);
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem_r[rp_r];
  assign fill      = cnt_r;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // storage
  always_ff @(posedge aclk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_r  <= '0;
      rp_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop)  rp_r <= rp_r + 1'b1;
      if (push & ~pop) cnt_r <= cnt_r + 1'b1;
      else if (pop & ~push) cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

module gac_option_ctrl #(
  parameter logic [7:0] PREP_OCTET    = 8'h3c,
  parameter logic [7:0] RELEASE_OCTET = 8'hc3,
  parameter int         PREP_COUNT    = 8,
  parameter int         FIFO_DEPTH    = 16
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite slave
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic      [1:0]        s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic      [31:0]       s_axi_rdata,
  output logic      [1:0]        s_axi_rresp,
  // terminal side
  input  wire logic              term_in_valid,
  output logic                   term_in_ready,
  input  wire logic [7:0]        term_in_data,
  output logic                   term_out_valid,
  output gac_pkg::gac_word_s     term_out_word,
  output logic      [3:0]        term_rate,
  input  wire logic              term_local_loopback_req,
  input  wire logic              term_remote_loopback_req,
  // front panel test switches
  input  wire logic              panel_local_loopback,
  input  wire logic              panel_remote_loopback,
  // line side
  output logic                   line_tx_pos,
  output logic                   line_tx_neg,
  input  wire logic              line_rx_pos,
  input  wire logic              line_rx_neg,
  input  wire logic              line_rx_strobe,
  output logic                   remote_loopback
);
  gac_pkg::gac_cfg_s   cfg_r;
  gac_pkg::gac_tm_e    tm_r;
  logic [2:0]          in_s1_r, in_s2_r;
  logic [2:0]          ln_s1_r, ln_s2_r;
  logic                strobe_d_r;
  logic                aw_hold_r, w_hold_r;
  logic [7:0]          aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;
  logic [31:0]         rd_word;
  logic [9:0]          bit_cnt_r;
  logic                bit_tick;
  logic [2:0]          tx_idx_r;
  logic [7:0]          tx_sh_r;
  logic                tx_pol_r;
  logic [2:0]          rx_idx_r;
  logic [7:0]          rx_sh_r;
  logic                rx_pol_r, rx_seen_r, rx_sync_r;
  logic [7:0]          rx_oct_r;
  logic                rx_oct_v_r;
  logic [7:0]          prep_cnt_r, rel_cnt_r;
  logic [7:0]          pend_cnt_r;
  logic                line_loop_r;
  logic                local_req, remote_req;
  logic                fifo_valid, fifo_ready;
  logic [7:0]          fifo_data;
  logic [$clog2(FIFO_DEPTH):0] fifo_fill;
  logic                rx_edge, rx_mark, rx_viol, rx_done;
  logic [7:0]          rx_next;
  logic [7:0]          tx_next;
  logic                tx_bit;

  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_s1_r    <= 3'h0;
      in_s2_r    <= 3'h0;
      ln_s1_r    <= 3'h0;
      ln_s2_r    <= 3'h0;
      strobe_d_r <= 1'b0;
    end else begin
      in_s1_r    <= {panel_remote_loopback, term_remote_loopback_req, 1'b0};
      in_s2_r    <= in_s1_r;
      ln_s1_r    <= {line_rx_strobe, line_rx_pos, line_rx_neg};
      ln_s2_r    <= ln_s1_r;
      strobe_d_r <= ln_s2_r[2];
    end
  end

  // local request synchronisers
  logic [1:0] loc_s1_r, loc_s2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loc_s1_r <= 2'h0;
      loc_s2_r <= 2'h0;
    end else begin
      loc_s1_r <= {panel_local_loopback, term_local_loopback_req};
      loc_s2_r <= loc_s1_r;
    end
  end

  // test requests gated by their enables
  assign local_req  = (cfg_r.panel_en & loc_s2_r[1]) | (cfg_r.term_ack_en & loc_s2_r[0]);
  assign remote_req = (cfg_r.panel_en & in_s2_r[2]) | (cfg_r.term_ack_en & in_s2_r[1]);

  // axi write, address and data in either order
  assign s_axi_awready = ~aw_hold_r & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_hold_r & ~s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r    <= 1'b0;
      w_hold_r     <= 1'b0;
      aw_addr_r    <= 8'h00;
      w_data_r     <= 32'h0000_0000;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= gac_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (aw_hold_r & w_hold_r) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == gac_pkg::ADDR_CTRL || aw_addr_r == gac_pkg::ADDR_STATUS) ?
                        gac_pkg::RESP_OKAY : gac_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // option settings; reserved bits are dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r.prep_rx_en  <= gac_pkg::RST_PREP_RX;
      cfg_r.octet_mode  <= gac_pkg::RST_OCTET;
      cfg_r.viol_en     <= gac_pkg::RST_VIOL;
      cfg_r.panel_en    <= gac_pkg::RST_PANEL;
      cfg_r.term_ack_en <= gac_pkg::RST_TACK;
      cfg_r.rate        <= gac_pkg::RST_RATE;
    end else if (aw_hold_r & w_hold_r & (aw_addr_r == gac_pkg::ADDR_CTRL)) begin
      if (w_strb_r[0]) begin
        cfg_r.prep_rx_en  <= w_data_r[gac_pkg::CTRL_PREP_BIT];
        cfg_r.octet_mode  <= w_data_r[gac_pkg::CTRL_OCTET_BIT];
        cfg_r.viol_en     <= w_data_r[gac_pkg::CTRL_VIOL_BIT];
        cfg_r.panel_en    <= w_data_r[gac_pkg::CTRL_PANEL_BIT];
        cfg_r.term_ack_en <= w_data_r[gac_pkg::CTRL_TACK_BIT];
      end
      if (w_strb_r[1]) begin
        cfg_r.rate <= w_data_r[gac_pkg::CTRL_RATE_LSB +: 4];
      end
    end
  end

  // read data mux
  always_comb begin
    rd_word = 32'h0000_0000;
    if (s_axi_araddr == gac_pkg::ADDR_CTRL) begin
      rd_word[gac_pkg::CTRL_PREP_BIT]      = cfg_r.prep_rx_en;
      rd_word[gac_pkg::CTRL_OCTET_BIT]     = cfg_r.octet_mode;
      rd_word[gac_pkg::CTRL_VIOL_BIT]      = cfg_r.viol_en;
      rd_word[gac_pkg::CTRL_PANEL_BIT]     = cfg_r.panel_en;
      rd_word[gac_pkg::CTRL_TACK_BIT]      = cfg_r.term_ack_en;
      rd_word[gac_pkg::CTRL_RATE_LSB +: 4] = cfg_r.rate;
    end else if (s_axi_araddr == gac_pkg::ADDR_STATUS) begin
      rd_word[gac_pkg::ST_TM_LSB +: 2]     = tm_r;
      rd_word[gac_pkg::ST_LLOOP_BIT]       = line_loop_r;
      rd_word[gac_pkg::ST_SYNC_BIT]        = rx_sync_r;
      rd_word[gac_pkg::ST_OCTET_BIT]       = cfg_r.octet_mode;
      rd_word[gac_pkg::ST_RATE_LSB +: 4]   = term_rate;
      rd_word[gac_pkg::ST_FILL_LSB +: ($clog2(FIFO_DEPTH)+1)] = fifo_fill;
    end
  end

  // axi read: one cycle from address to data
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= gac_pkg::RESP_OKAY;
    end else if (s_axi_arvalid & s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (s_axi_araddr == gac_pkg::ADDR_CTRL || s_axi_araddr == gac_pkg::ADDR_STATUS) ?
                      gac_pkg::RESP_OKAY : gac_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // octet mode forces the 128 kbps rate
  assign term_rate = cfg_r.octet_mode ? gac_pkg::RATE_128K : cfg_r.rate;

  // transmit fifo; ready back-pressures the terminal
  gac_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (term_in_valid),
    .in_ready  (term_in_ready),
    .in_data   (term_in_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .out_data  (fifo_data),
    .fill      (fifo_fill)
  );

  // local test mode sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tm_r       <= gac_pkg::TM_NORMAL;
      pend_cnt_r <= 8'h00;
    end else begin
      case (tm_r)
        gac_pkg::TM_NORMAL: begin
          if (local_req) tm_r <= gac_pkg::TM_LOCAL;
          else if (remote_req) tm_r <= gac_pkg::TM_PREP;
          pend_cnt_r <= 8'h00;
        end
        gac_pkg::TM_LOCAL: begin
          if (!local_req) tm_r <= gac_pkg::TM_NORMAL;
        end
        gac_pkg::TM_PREP: begin
          if (!remote_req) tm_r <= gac_pkg::TM_RELEASE;
        end
        gac_pkg::TM_RELEASE: begin
          if (bit_tick && tx_idx_r == 3'h0) pend_cnt_r <= pend_cnt_r + 8'h01;
          if (pend_cnt_r == PREP_COUNT[7:0]) tm_r <= gac_pkg::TM_NORMAL;
        end
        default: tm_r <= gac_pkg::TM_NORMAL;
      endcase
    end
  end

  // 64 kbps symbol timer, free running so transmit never waits on receive
  assign bit_tick = (bit_cnt_r == 10'(gac_pkg::BIT_CYC - 1));
  always_ff @(posedge aclk) begin
    if (!aresetn) bit_cnt_r <= 10'h000;
    else bit_cnt_r <= bit_tick ? 10'h000 : bit_cnt_r + 10'h001;
  end

  // octet source: looped line data, pattern octets, user data or idle
  always_comb begin
    tx_next = gac_pkg::IDLE_OCTET;
    if (line_loop_r) tx_next = rx_oct_r;
    else if (tm_r == gac_pkg::TM_PREP) tx_next = PREP_OCTET;
    else if (tm_r == gac_pkg::TM_RELEASE) tx_next = RELEASE_OCTET;
    else if (tm_r == gac_pkg::TM_NORMAL && fifo_valid) tx_next = fifo_data;
  end
  assign fifo_ready = bit_tick & (tx_idx_r == 3'h0) &
                      ((tm_r == gac_pkg::TM_LOCAL) | (tm_r == gac_pkg::TM_NORMAL & ~line_loop_r));
  assign tx_bit = (tx_idx_r == 3'h0) ? tx_next[7] : tx_sh_r[7];

  // line transmitter: alternate mark polarity, violation on last bit of octet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_idx_r    <= 3'h0;
      tx_sh_r     <= 8'h00;
      tx_pol_r    <= 1'b0;
      line_tx_pos <= 1'b0;
      line_tx_neg <= 1'b0;
    end else if (bit_tick) begin
      tx_idx_r <= tx_idx_r + 3'h1;
      tx_sh_r  <= (tx_idx_r == 3'h0) ? {tx_next[6:0], 1'b0} : {tx_sh_r[6:0], 1'b0};
      if (tx_idx_r == 3'h7 && cfg_r.viol_en) begin
        line_tx_pos <= tx_pol_r;  // repeat last polarity
        line_tx_neg <= ~tx_pol_r;
      end else if (tx_bit) begin
        line_tx_pos <= ~tx_pol_r;
        line_tx_neg <= tx_pol_r;
        tx_pol_r    <= ~tx_pol_r;
      end else begin
        line_tx_pos <= 1'b0;
        line_tx_neg <= 1'b0;
      end
    end
  end

  // receive symbol decode on each rising strobe edge
  assign rx_edge = ln_s2_r[2] & ~strobe_d_r;
  assign rx_mark = ln_s2_r[1] | ln_s2_r[0];
  assign rx_viol = rx_mark & rx_seen_r & (ln_s2_r[1] == rx_pol_r);
  assign rx_done = rx_viol | (rx_idx_r == 3'h7);
  assign rx_next = {rx_sh_r[6:0], rx_mark};

  // line receiver: octet alignment from violations, else free count of eight
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_idx_r   <= 3'h0;
      rx_sh_r    <= 8'h00;
      rx_pol_r   <= 1'b0;
      rx_seen_r  <= 1'b0;
      rx_sync_r  <= 1'b0;
      rx_oct_r   <= 8'h00;
      rx_oct_v_r <= 1'b0;
    end else begin
      rx_oct_v_r <= rx_edge & rx_done;
      if (rx_edge) begin
        rx_sh_r  <= rx_next;
        rx_idx_r <= rx_done ? 3'h0 : rx_idx_r + 3'h1;
        if (rx_done) rx_oct_r <= rx_next;
        if (rx_viol) rx_sync_r <= 1'b1;
        if (rx_mark) begin
          rx_pol_r  <= ln_s2_r[1];
          rx_seen_r <= 1'b1;
        end
      end
    end
  end

  // line pattern detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prep_cnt_r  <= 8'h00;
      rel_cnt_r   <= 8'h00;
      line_loop_r <= 1'b0;
    end else if (!cfg_r.prep_rx_en) begin
      prep_cnt_r  <= 8'h00;
      rel_cnt_r   <= 8'h00;
      line_loop_r <= 1'b0;
    end else if (rx_oct_v_r) begin
      prep_cnt_r <= (rx_oct_r == PREP_OCTET) ? prep_cnt_r + 8'h01 : 8'h00;
      rel_cnt_r  <= (rx_oct_r == RELEASE_OCTET) ? rel_cnt_r + 8'h01 : 8'h00;
      if (rx_oct_r == PREP_OCTET && prep_cnt_r == 8'(PREP_COUNT - 1)) line_loop_r <= 1'b1;
      if (rx_oct_r == RELEASE_OCTET && rel_cnt_r == 8'(PREP_COUNT - 1)) line_loop_r <= 1'b0;
    end
  end
  assign remote_loopback = line_loop_r;

  // terminal output: echo in local loopback, else line octets
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      term_out_valid <= 1'b0;
      term_out_word  <= '0;
    end else if (tm_r == gac_pkg::TM_LOCAL) begin
      term_out_valid           <= fifo_ready & fifo_valid;
      term_out_word.data       <= fifo_data;
      term_out_word.octet_mark <= cfg_r.octet_mode;
    end else begin
      term_out_valid           <= rx_oct_v_r;
      term_out_word.data       <= rx_oct_r;
      term_out_word.octet_mark <= cfg_r.octet_mode & rx_sync_r;
    end
  end
endmodule

`default_nettype wire

/* File: design/gac_pkg.sv */
// package of the option-control block
package gac_pkg;

  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;

  // control register field positions
  localparam int CTRL_PREP_BIT  = 0;
  localparam int CTRL_OCTET_BIT = 1;
  localparam int CTRL_VIOL_BIT  = 2;
  localparam int CTRL_PANEL_BIT = 3;
  localparam int CTRL_TACK_BIT  = 4;
  localparam int CTRL_RATE_LSB  = 8;

  // status register field positions
  localparam int ST_TM_LSB    = 0;
  localparam int ST_LLOOP_BIT = 2;
  localparam int ST_SYNC_BIT  = 3;
  localparam int ST_OCTET_BIT = 4;
  localparam int ST_RATE_LSB  = 8;
  localparam int ST_FILL_LSB  = 16;

  // reset values of the control fields
  localparam logic       RST_PREP_RX  = 1'b1;
  localparam logic       RST_OCTET    = 1'b0;
  localparam logic       RST_VIOL     = 1'b0;
  localparam logic       RST_PANEL    = 1'b1;
  localparam logic       RST_TACK     = 1'b1;
  localparam logic [3:0] RST_RATE     = 4'hf;   // 64 kbps terminal rate
  localparam logic [3:0] RATE_128K    = 4'h0;   // octet mode rate code

  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // line timing: one 64 kbps symbol at a 40 mhz clock
  localparam int CLK_PERIOD_NS = 25;
  localparam int BIT_TIME_NS   = 15625;
  localparam int BIT_CYC       = BIT_TIME_NS / CLK_PERIOD_NS;

  // idle line octet
  localparam logic [7:0] IDLE_OCTET = 8'hff;

  // option settings as one bundle
  typedef struct packed {
    logic [3:0] rate;
    logic       term_ack_en;
    logic       panel_en;
    logic       viol_en;
    logic       octet_mode;
    logic       prep_rx_en;
  } gac_cfg_s;

  // terminal word
  typedef struct packed {
    logic       octet_mark;
    logic [7:0] data;
  } gac_word_s;

  // local test mode
  typedef enum logic [1:0] {
    TM_NORMAL  = 2'b00,
    TM_LOCAL   = 2'b01,
    TM_PREP    = 2'b10,
    TM_RELEASE = 2'b11
  } gac_tm_e;

endpackage

/* File: testbench/gac_option_ctrl_sva.sv */
// port assertions of the option-control block
`timescale 1ns/100ps
`default_nettype none
module gac_option_ctrl_sva (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        term_out_valid,
  input wire logic        line_tx_pos,
  input wire logic        line_tx_neg
);
  logic [1:0]  tx_prev_r;
  logic        tx_seen_r;
  logic [19:0] gap_r;
  logic        tx_chg;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // cycles since last line symbol change
  assign tx_chg = ({line_tx_pos, line_tx_neg} != tx_prev_r);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_prev_r <= 2'h0;
      tx_seen_r <= 1'b0;
      gap_r     <= 20'h0;
    end else begin
      tx_prev_r <= {line_tx_pos, line_tx_neg};
      tx_seen_r <= tx_seen_r | tx_chg;
      gap_r     <= tx_chg ? 20'h0 : gap_r + 20'h1;
    end
  end

  // write address and data taken on one edge; read address taken
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence

  wr_answer_a: assert property (wr_taken |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("late read data");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while busy");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  wr_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
  rd_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data not released");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp == gac_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  out_pulse_a: assert property (term_out_valid |=> !term_out_valid)
    else $error("long terminal pulse");
  tx_polar_a: assert property (!(line_tx_pos && line_tx_neg))
    else $error("both line polarities driven");
  tx_symbol_a: assert property (tx_chg && tx_seen_r |-> (gap_r % gac_pkg::BIT_CYC) == gac_pkg::BIT_CYC - 1)
    else $error("symbol off grid");
endmodule

bind gac_option_ctrl gac_option_ctrl_sva i_sva (.*);
`default_nettype wire

/* File: testbench/gac_line_model.sv */
// far-end line model
`timescale 1ns/100ps
`default_nettype none
module gac_line_model #(
  parameter int HALF = 8
) (
  input  wire logic aclk,
  output logic      line_rx_pos,
  output logic      line_rx_neg,
  output logic      line_rx_strobe
);
  logic last_pos;

  // quiet line, strobe still
  initial begin
    line_rx_pos    = 1'b0;
    line_rx_neg    = 1'b0;
    line_rx_strobe = 1'b0;
    last_pos       = 1'b0;
  end

  // sends n copies of an octet msb first, marks alternating in polarity
  task automatic send(input logic [7:0] v, input int n);
    for (int k = 0; k < n; k++) begin
      for (int b = 7; b >= 0; b--) begin
        @(posedge aclk);
        line_rx_pos <= v[b] & ~last_pos;
        line_rx_neg <= v[b] & last_pos;
        last_pos = last_pos ^ v[b];
        repeat (HALF) @(posedge aclk);
        line_rx_strobe <= 1'b1;
        repeat (HALF) @(posedge aclk);
        line_rx_strobe <= 1'b0;
      end
    end
    @(posedge aclk);
    line_rx_pos <= 1'b0;
    line_rx_neg <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: testbench/gac_option_ctrl_bench.sv */
// self-checking testbench of the option-control block
`timescale 1ns/100ps
`default_nettype none
module gac_option_ctrl_bench;
  localparam logic [7:0]  PREP = 8'h3c;
  localparam logic [7:0]  REL  = 8'hc3;
  localparam logic [31:0] CTRL_RST = {20'h0, gac_pkg::RST_RATE, 3'h0, gac_pkg::RST_TACK, gac_pkg::RST_PANEL,
                                      gac_pkg::RST_VIOL, gac_pkg::RST_OCTET, gac_pkg::RST_PREP_RX};
  logic               aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic               s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, term_in_valid;
  logic               term_in_ready, term_out_valid, term_local_loopback_req, term_remote_loopback_req;
  logic               panel_local_loopback, panel_remote_loopback, line_tx_pos, line_tx_neg, remote_loopback;
  logic               line_rx_pos, line_rx_neg, line_rx_strobe;
  logic [7:0]         s_axi_awaddr, s_axi_araddr, term_in_data;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic [3:0]         s_axi_wstrb, term_rate;
  gac_pkg::gac_word_s term_out_word;
  int                 n_fail, comparisons, cyc, viol_cnt, pos_run, neg_run;

  gac_option_ctrl #(.PREP_OCTET(PREP), .RELEASE_OCTET(REL), .PREP_COUNT(2), .FIFO_DEPTH(4)) i_dut (.*);
  gac_line_model i_line (.*);

  // clock of 25 ns
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // same-polarity runs over one symbol are violations; run timeout
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    pos_run <= line_tx_pos ? pos_run + 1 : 0;
    neg_run <= line_tx_neg ? neg_run + 1 : 0;
    if (pos_run == 1000 || neg_run == 1000) viol_cnt <= viol_cnt + 1;
    if (cyc == 60000) begin
      n_fail++;
      $display("Error at %0t: run timed out", $time);
      final_report;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er}, "write response");
  endtask

  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    s_axi_araddr <= a;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    d = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, er}, "read response");
  endtask

  task automatic tmode(input logic [1:0] exp);
    logic [31:0] s;
    rd(gac_pkg::ADDR_STATUS, gac_pkg::RESP_OKAY, s);
    chk({30'h0, s[gac_pkg::ST_TM_LSB +: 2]}, {30'h0, exp}, "test mode");
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // reset values, unmapped and read-only places
  task automatic t_reset;
    logic [31:0] d;
    rd(gac_pkg::ADDR_CTRL, gac_pkg::RESP_OKAY, d);
    chk(d, CTRL_RST, "control after reset");
    chk({28'h0, term_rate}, {28'h0, gac_pkg::RST_RATE}, "rate after reset");
    rd(8'h08, gac_pkg::RESP_SLVERR, d);
    chk(d, 32'h0, "unmapped read");
    wr(8'h0c, 32'hffffffff, gac_pkg::RESP_SLVERR);
    wr(gac_pkg::ADDR_STATUS, 32'hffffffff, gac_pkg::RESP_OKAY);
    rd(gac_pkg::ADDR_CTRL, gac_pkg::RESP_OKAY, d);
    chk(d, CTRL_RST, "control after stray writes");
    tmode(gac_pkg::TM_NORMAL);
  endtask

  // rate field in clear channel, overridden in octet mode
  task automatic t_rate;
    wr(gac_pkg::ADDR_CTRL, 32'h00000519, gac_pkg::RESP_OKAY);
    chk({28'h0, term_rate}, 32'h5, "clear channel rate");
    wr(gac_pkg::ADDR_CTRL, 32'h0000051b, gac_pkg::RESP_OKAY);
    chk({28'h0, term_rate}, {28'h0, gac_pkg::RATE_128K}, "octet mode rate");
    wr(gac_pkg::ADDR_CTRL, CTRL_RST, gac_pkg::RESP_OKAY);
  endtask

  // line loopback honoured, then refused
  task automatic t_line;
    i_line.send(PREP, 3);
    idle(20);
    chk({31'h0, remote_loopback}, 32'h1, "loop entered");
    i_line.send(REL, 8);
    idle(20);
    chk({31'h0, remote_loopback}, 32'h0, "loop released");
    wr(gac_pkg::ADDR_CTRL, 32'h00000f18, gac_pkg::RESP_OKAY);
    i_line.send(PREP, 3);
    idle(20);
    chk({31'h0, remote_loopback}, 32'h0, "loop ignored");
  endtask

  // panel and terminal gates, then local loop through a full fifo in octet mode
  task automatic t_local;
    int i;
    wr(gac_pkg::ADDR_CTRL, 32'h00000f03, gac_pkg::RESP_OKAY);
    {panel_local_loopback, term_local_loopback_req} <= 2'b11;
    idle(10);
    tmode(gac_pkg::TM_NORMAL);
    wr(gac_pkg::ADDR_CTRL, 32'h00000f1b, gac_pkg::RESP_OKAY);
    idle(10);
    tmode(gac_pkg::TM_LOCAL);
    i = 0;
    term_in_valid <= 1'b1;
    term_in_data <= 8'ha0;
    fork
      begin
        do begin
          @(posedge aclk);
          if (term_in_ready) i++;
          term_in_data <= 8'ha0 + i[7:0];
        end while (term_in_ready && i < 8);
        term_in_valid <= 1'b0;
        chk({31'h0, i >= 4 && i <= 5}, 32'h1, "fifo refusal");
      end
      for (int j = 0; j < 4; j++) begin
        do @(posedge aclk); while (term_out_valid !== 1'b1);
        chk({23'h0, term_out_word}, {23'h0, 1'b1, 8'ha0 + j[7:0]}, "looped octet");
      end
    join
    {panel_local_loopback, term_local_loopback_req} <= 2'b00;
    idle(10);
    tmode(gac_pkg::TM_NORMAL);
  endtask

  // violations on the transmitted line only when enabled
  task automatic t_viol;
    int base;
    wr(gac_pkg::ADDR_CTRL, CTRL_RST, gac_pkg::RESP_OKAY);
    base = viol_cnt;
    idle(12000);
    chk(viol_cnt - base, 32'h0, "violations while disabled");
    wr(gac_pkg::ADDR_CTRL, 32'h00000f1d, gac_pkg::RESP_OKAY);
    base = viol_cnt;
    idle(12000);
    chk({31'h0, viol_cnt > base}, 32'h1, "violations while enabled");
  endtask

  // own loopback request, line reception off
  task automatic t_own;
    wr(gac_pkg::ADDR_CTRL, 32'h00000f00, gac_pkg::RESP_OKAY);
    {panel_remote_loopback, term_remote_loopback_req} <= 2'b11;
    idle(10);
    tmode(gac_pkg::TM_NORMAL);
    wr(gac_pkg::ADDR_CTRL, 32'h00000f18, gac_pkg::RESP_OKAY);
    idle(10);
    tmode(gac_pkg::TM_PREP);
    {panel_remote_loopback, term_remote_loopback_req} <= 2'b00;
    idle(10);
    tmode(gac_pkg::TM_RELEASE);
  endtask

  task automatic final_report;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // reset for 8 cycles, then the scenarios in order
  initial begin
    {aresetn, s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_bready, s_axi_arvalid} = '0;
    {s_axi_araddr, s_axi_rready, term_in_valid, term_in_data, term_local_loopback_req} = '0;
    {term_remote_loopback_req, panel_local_loopback, panel_remote_loopback} = '0;
    s_axi_wstrb = 4'hf;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_rate;
    t_line;
    t_local;
    t_viol;
    t_own;
    final_report;
  end
endmodule
`default_nettype wire
